//--- verilog/ppm_cfg.svh
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH

`define PPM_OFF_MODE      8'h00
`define PPM_OFF_TIMER     8'h04
`define PPM_OFF_START     8'h08
`define PPM_OFF_STATUS    8'h0C

`define PPM_MODE_WIDTH_BIT   3
`define PPM_MODE_SRC_LO      6
`define PPM_MODE_SRC_HI      7
`define PPM_MODE_OP_VAL      2'h2

`define PPM_START_BIT        0
`define PPM_STAT_IRQ_BIT     0
`define PPM_STAT_OVF_BIT     1
`define PPM_STAT_VALID_BIT   2
`define PPM_STAT_LEVEL_BIT   3

`define PPM_CNT_RST          16'h0000
`define PPM_CNT_MAX          16'hFFFF
`define PPM_DIV8_LAST        3'h7
`define PPM_DIV32_LAST       5'h1F

`endif

//--- verilog/ppm_pkg.sv
package ppm_pkg;

	typedef enum logic [1:0] {
		PPM_SRC_DIV1,
		PPM_SRC_DIV8,
		PPM_SRC_DIV32,
		PPM_SRC_SUB32
	} ppm_src_t;

	typedef enum logic [1:0] {
		PPM_PH_STOPPED,
		PPM_PH_FIRST,
		PPM_PH_SECOND,
		PPM_PH_VALID
	} ppm_phase_t;

	typedef struct packed {
		logic [4:0] main_cnt;
		logic [4:0] sub_cnt;
		logic       sub_sync1;
		logic       sub_sync2;
		logic       sub_last;
		logic       sub_tick;
	} ppm_pre_state_t;

	typedef struct packed {
		logic [15:0] counter;
		logic [15:0] reload;
		logic [31:0] prdata;
		ppm_src_t    src;
		logic        width_sel;
		logic        start;
		logic        ovf;
		logic        irq;
		ppm_phase_t  phase;
		logic        pin_sync1;
		logic        pin_sync2;
		logic        level;
	} ppm_state_t;

endpackage : ppm_pkg

//--- verilog/ppm_prescale.sv
`timescale 1ns/1ps
`include "ppm_cfg.svh"

module ppm_prescale (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic sub_clk,
	output logic      clk_div1,
	output logic      clk_div8,
	output logic      clk_div32,
	output logic      subclk_div32
);

	ppm_pkg::ppm_pre_state_t st_reg;
	ppm_pkg::ppm_pre_state_t st_next;

	always_comb begin
		st_next           = st_reg;
		st_next.main_cnt  = st_reg.main_cnt + 5'h01;
		st_next.sub_sync1 = sub_clk;
		st_next.sub_sync2 = st_reg.sub_sync1;
		st_next.sub_last  = st_reg.sub_sync2;
		st_next.sub_tick  = 1'b0;
		// sub clock is far slower than clock, so edge counting is enough
		if (st_reg.sub_sync2 && !st_reg.sub_last) begin
			st_next.sub_cnt = st_reg.sub_cnt + 5'h01;
			if (st_reg.sub_cnt == `PPM_DIV32_LAST) begin
				st_next.sub_tick = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign clk_div1     = 1'b1;
	assign clk_div8     = (st_reg.main_cnt[2:0] == `PPM_DIV8_LAST);
	assign clk_div32    = (st_reg.main_cnt == `PPM_DIV32_LAST);
	assign subclk_div32 = st_reg.sub_tick;

endmodule : ppm_prescale

//--- verilog/ppm_timer.sv
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "ppm_cfg.svh"

// Notes on behaviour
// - while measuring, the counter adds one on every tick of the chosen count clock.
// - each effective edge copies the counter into the reload register, zeroes the counter and counting goes on.
// - counting begins when software sets the count start flag.
// - counting halts when software clears the count start flag.
// - each effective edge raises the interrupt request, except as below.
// - the first effective edge after counting starts raises no interrupt request.
// - a counter overflow raises the interrupt request and sets the overflow flag in the same cycle.
// - any write to the mode register while the start flag is set clears the overflow flag.
// - reading the timer register returns the reload register, not the live counter.
// - the timer value is not valid until the second effective edge after start has been captured.
// - writes to the timer register change neither counter nor reload register.
// - in period measurement the interval between successive falling edges is captured.
// - the pending interrupt request is cleared on acceptance by the controller or by software.
// - mode bits 7:6 pick the count clock: undivided, divide by 8, divide by 32, sub clock divide by 32.

module ppm_timer (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        measure_pulse_pin,
	input  wire logic        sub_clk,
	input  wire logic        irq_ack,
	output logic             irq_req
);

	ppm_pkg::ppm_state_t st_reg;
	ppm_pkg::ppm_state_t st_next;

	logic clk_div1;
	logic clk_div8;
	logic clk_div32;
	logic subclk_div32;

	logic count_tick;
	logic mapped;
	logic wr_access;
	logic rd_setup;
	logic wr_mode;
	logic wr_timer;
	logic wr_start;
	logic wr_status;
	logic eff_edge;
	logic fall_edge;
	logic any_edge;

	ppm_prescale u_prescale (
		.clock        (clock),
		.rst_n        (rst_n),
		.sub_clk      (sub_clk),
		.clk_div1     (clk_div1),
		.clk_div8     (clk_div8),
		.clk_div32    (clk_div32),
		.subclk_div32 (subclk_div32)
	);

	// count source select
	always_comb begin
		unique case (st_reg.src)
			ppm_pkg::PPM_SRC_DIV1: begin
				count_tick = clk_div1;
			end
			ppm_pkg::PPM_SRC_DIV8: begin
				count_tick = clk_div8;
			end
			ppm_pkg::PPM_SRC_DIV32: begin
				count_tick = clk_div32;
			end
			ppm_pkg::PPM_SRC_SUB32: begin
				count_tick = subclk_div32;
			end
		endcase
	end

	// bus decode; the slave never inserts wait states
	always_comb begin
		mapped    = (paddr == `PPM_OFF_MODE)
		         || (paddr == `PPM_OFF_TIMER)
		         || (paddr == `PPM_OFF_START)
		         || (paddr == `PPM_OFF_STATUS);
		wr_access = psel && penable && pwrite && mapped;
		rd_setup  = psel && !penable && !pwrite;
		wr_mode   = wr_access && (paddr == `PPM_OFF_MODE);
		wr_timer  = wr_access && (paddr == `PPM_OFF_TIMER);
		wr_start  = wr_access && (paddr == `PPM_OFF_START);
		wr_status = wr_access && (paddr == `PPM_OFF_STATUS);
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// edges are judged on the level held at the previous count tick
	always_comb begin
		fall_edge = st_reg.level && !st_reg.pin_sync2;
		any_edge  = st_reg.level != st_reg.pin_sync2;
		if (st_reg.width_sel) begin
			eff_edge = any_edge;
		end else begin
			eff_edge = fall_edge;
		end
	end

	always_comb begin
		st_next           = st_reg;

		// plain two-stage synchroniser on the pin
		st_next.pin_sync1 = measure_pulse_pin;
		st_next.pin_sync2 = st_reg.pin_sync1;

		// mode register write
		if (wr_mode) begin
			st_next.src       = ppm_pkg::ppm_src_t'(
				pwdata[`PPM_MODE_SRC_HI:`PPM_MODE_SRC_LO]);
			st_next.width_sel = pwdata[`PPM_MODE_WIDTH_BIT];
			if (st_reg.start) begin
				st_next.ovf = 1'b0;
			end
		end

		// timer writes are accepted on the bus but dropped
		if (wr_timer) begin
			st_next.reload  = st_reg.reload;
			st_next.counter = st_reg.counter;
		end

		// start flag
		if (wr_start) begin
			st_next.start = pwdata[`PPM_START_BIT];
			if (pwdata[`PPM_START_BIT] && !st_reg.start) begin
				// restart measurement; current synchronised pin level taken as reference
				st_next.phase   = ppm_pkg::PPM_PH_FIRST;
				st_next.counter = `PPM_CNT_RST;
				st_next.level   = st_reg.pin_sync2;
			end
			if (!pwdata[`PPM_START_BIT]) begin
				st_next.phase = ppm_pkg::PPM_PH_STOPPED;
			end
		end

		// request clears come first so a same-cycle set wins
		if (irq_ack) begin
			st_next.irq = 1'b0;
		end
		if (wr_status && pwdata[`PPM_STAT_IRQ_BIT]) begin
			st_next.irq = 1'b0;
		end

		// measurement on count ticks only
		if (st_reg.start && count_tick) begin
			st_next.level = st_reg.pin_sync2;
			if (eff_edge) begin
				st_next.reload  = st_reg.counter;
				st_next.counter = `PPM_CNT_RST;
				unique case (st_reg.phase)
					ppm_pkg::PPM_PH_FIRST: begin
						// first edge only opens the interval
						st_next.phase = ppm_pkg::PPM_PH_SECOND;
					end
					ppm_pkg::PPM_PH_SECOND: begin
						st_next.phase = ppm_pkg::PPM_PH_VALID;
						st_next.irq   = 1'b1;
					end
					ppm_pkg::PPM_PH_VALID: begin
						st_next.irq = 1'b1;
					end
					ppm_pkg::PPM_PH_STOPPED: begin
						st_next.irq = 1'b1;
					end
				endcase
			end else begin
				st_next.counter = st_reg.counter + 16'h0001;
				if (st_reg.counter == `PPM_CNT_MAX) begin
					// wraps to zero; result of this interval is lost
					st_next.ovf = 1'b1;
					st_next.irq = 1'b1;
				end
			end
		end

		// read data is fetched in the setup phase
		if (rd_setup) begin
			st_next.prdata = 32'h0000_0000;
			unique case (paddr)
				`PPM_OFF_MODE: begin
					st_next.prdata[1:0] = `PPM_MODE_OP_VAL;
					st_next.prdata[`PPM_MODE_WIDTH_BIT] = st_reg.width_sel;
					st_next.prdata[`PPM_MODE_SRC_HI:`PPM_MODE_SRC_LO] =
						st_reg.src;
				end
				`PPM_OFF_TIMER: begin
					st_next.prdata[15:0] = st_reg.reload;
				end
				`PPM_OFF_START: begin
					st_next.prdata[`PPM_START_BIT] = st_reg.start;
				end
				`PPM_OFF_STATUS: begin
					st_next.prdata[`PPM_STAT_IRQ_BIT]   = st_reg.irq;
					st_next.prdata[`PPM_STAT_OVF_BIT]   = st_reg.ovf;
					st_next.prdata[`PPM_STAT_VALID_BIT] =
						(st_reg.phase == ppm_pkg::PPM_PH_VALID);
					st_next.prdata[`PPM_STAT_LEVEL_BIT] = st_reg.level;
				end
				default: begin
					st_next.prdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata  = st_reg.prdata;
	assign irq_req = st_reg.irq;

endmodule : ppm_timer

//--- testbench/ppm_properties.sv
`timescale 1ns/1ps
module ppm_timer_properties (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq_ack,
	input wire logic        irq_req
);
	logic acc;
	logic rd;
	logic map;
	logic clr;
	logic st_reg;
	assign acc = psel && penable;
	assign rd  = acc && !pwrite;
	assign map = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
	assign clr = acc && pwrite && paddr == 8'h0C && pwdata[0];
	// mirror of the start flag, so irq changes can be tied to it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			st_reg <= 1'b0;
		else if (acc && pwrite && paddr == 8'h08)
			st_reg <= pwdata[0];
	end
	default clocking dc @(posedge clock); endclocking
	default disable iff (!rst_n);
	no_wait_a: assert property (psel |-> pready)
		else $error("pready low");
	bad_addr_a: assert property (rd && !map |-> pslverr && prdata == 32'h0)
		else $error("unmapped read accepted");
	good_addr_a: assert property (acc && map |-> !pslverr)
		else $error("mapped access refused");
	mode_read_a: assert property (rd && paddr == 8'h00 |-> prdata[1:0] == 2'h2)
		else $error("mode field wrong");
	timer_read_a: assert property (rd && paddr == 8'h04 |-> prdata[31:16] == 16'h0)
		else $error("timer upper bits set");
	irq_stop_a: assert property ($rose(irq_req) |-> $past(st_reg))
		else $error("irq while halted");
	irq_clear_a: assert property ($fell(irq_req) |-> $past(irq_ack) || $past(clr))
		else $error("irq dropped by itself");
	ack_clear_a: assert property (irq_ack && !st_reg |=> !irq_req)
		else $error("irq kept after accept");
endmodule : ppm_timer_properties

//--- testbench/ppm_pulse_src.sv
`timescale 1ns/1ps
module ppm_pulse_src (
	input  wire logic        clock,
	input  wire logic        en,
	input  wire logic [15:0] half_len,
	output logic             pulse
);
	logic [15:0] cnt;
	initial pulse = 1'b1;
	initial cnt = 16'h0001;
	// idles high so the first edge after enable is a fall
	always @(posedge clock) begin
		if (!en) begin
			pulse <= 1'b1;
			cnt <= 16'h0001;
		end else if (cnt >= half_len) begin
			pulse <= !pulse;
			cnt <= 16'h0001;
		end else
			cnt <= cnt + 16'h0001;
	end
endmodule : ppm_pulse_src

//--- testbench/tb_ppm_timer.sv
`timescale 1ns/1ps
module tb_ppm_timer;
	logic        clock, rst_n, psel, penable, pwrite, irq_ack, sub_clk;
	logic        pin_en, pready, pslverr, irq_req, pin;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] half_len, lfsr;
	int          l, u, n, n_fail, total_checks;
	ppm_timer ppm_timer_inst (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.measure_pulse_pin(pin), .sub_clk(sub_clk), .irq_ack(irq_ack),
		.irq_req(irq_req));
	ppm_pulse_src ppm_pulse_src_inst (.clock(clock), .en(pin_en),
		.half_len(half_len), .pulse(pin));
	initial begin
		clock = 1'b0;
		forever #25 clock = !clock;
	end
	always @(posedge clock) sub_clk <= !sub_clk;
	function logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nxt
	task end_of_test();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task cmp(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		// only the watchdog ends a wait for the answer
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		psel <= 1'b0; penable <= 1'b0;
		// idle edge keeps two calls from driving psel twice in one step
		@(posedge clock);
	endtask : apb
	initial begin
		repeat (99000) @(posedge clock);
		n_fail++;
		end_of_test();
	end
	initial begin
		{psel, penable, pwrite, irq_ack, sub_clk, pin_en, rst_n} = 7'h00;
		paddr = 8'h00; pwdata = 32'h0; half_len = 16'h0008; lfsr = 16'h0039;
		n_fail = 0; total_checks = 0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		apb(1'b0, 8'h0C, 32'h0); cmp(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		for (int m = 0; m < 8; m++) begin
			lfsr = nxt(lfsr);
			l = 8 + lfsr[2:0];
			u = (m < 2) ? 1 : (m < 4) ? 8 : (m < 6) ? 32 : 64;
			n = m[0] ? l : 2 * l;
			half_len <= 16'(l * u);
			apb(1'b1, 8'h00, {24'h0, 2'(m >> 1), 2'h0, m[0], 3'h2});
			apb(1'b0, 8'h00, 32'h0);
			cmp(rd, {24'h0, 2'(m >> 1), 2'h0, m[0], 3'h2});
			apb(1'b1, 8'h08, 32'h1);
			pin_en <= 1'b1;
			repeat (l * u * 3 / 2) @(posedge clock);
			cmp(irq_req, 1'b0);
			repeat (l * u * 3) @(posedge clock);
			apb(1'b0, 8'h0C, 32'h0); cmp(rd[2:0], 3'h5);
			apb(1'b0, 8'h04, 32'h0); cmp(rd, n - 1);
			apb(1'b1, 8'h08, 32'h0);
			apb(1'b1, 8'h04, 32'hFFFF);
			repeat (l * u * 3) @(posedge clock);
			apb(1'b0, 8'h04, 32'h0); cmp(rd, n - 1);
			cmp(irq_req, 1'b1);
			irq_ack <= 1'b1;
			@(posedge clock);
			irq_ack <= 1'b0;
			pin_en <= 1'b0;
			@(posedge clock);
			cmp(irq_req, 1'b0);
			$display("test %0d done", m);
		end
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b1, 8'h08, 32'h1);
		repeat (65540) @(posedge clock);
		apb(1'b0, 8'h0C, 32'h0); cmp(rd[1:0], 2'h3);
		apb(1'b1, 8'h0C, 32'h1);
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b0, 8'h0C, 32'h0); cmp(rd[1:0], 2'h0);
		$display("overflow test done");
		end_of_test();
	end
endmodule : tb_ppm_timer
bind ppm_timer ppm_timer_properties ppm_timer_properties_inst (.clock(clock),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq_ack(irq_ack), .irq_req(irq_req));
